// ==== hw/cic_map.vh ====
// Register map, field positions and timing constants of the interrupt controller
`ifndef CIC_MAP_VH
`define CIC_MAP_VH

// Byte offsets on the register bus
`define CIC_OFS_CTRL 12'h000
`define CIC_OFS_OPTION 12'h004
`define CIC_OFS_CHGFLG 12'h008
`define CIC_OFS_STATE 12'h00c
`define CIC_OFS_SHADOW 12'h020
`define CIC_SHADOW_BASE 7'h01

// Control register fields
`define CIC_B_GLOBAL_EN 7
`define CIC_B_PERIPH_EN 6
`define CIC_B_TIMER0_EN 5
`define CIC_B_PIN_EN 4
`define CIC_B_CHANGE_EN 3
`define CIC_B_TIMER0_FLAG 2
`define CIC_B_PIN_FLAG 1
`define CIC_B_CHANGE_FLAG 0
`define CIC_CTRL_RST 8'h00

// Option register: edge select for the pin interrupt
`define CIC_B_EDGE 0
`define CIC_OPTION_RST 1'b1

// Shadow layout: byte 0 accumulator, byte 1 status, 2 bank, 3..6 pointers, 7 pc high latch
`define CIC_SHD_STATUS 1
`define CIC_STATUS_KEEP 8'he7

// Vector and instruction cycle shape
`define CIC_VECTOR 15'h0004
`define CIC_Q_PHASES 4

`endif

// ==== hw/cic_sync.v ====
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module cic_sync #(
  parameter WIDTH = 1
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

// ==== hw/cic_top.v ====
// Interrupt controller of the 8-bit core: flags, enables, entry, return, wake and shadows
`timescale 1ns/1ns
`include "cic_map.vh"
module cic_top #(
  parameter CHG_N = 6,
  parameter Q_DIV = 1
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_pin,
  input wire [CHG_N-1:0] change_pins,
  input wire timer0_overflow,
  input wire periph_irq_pending,
  input wire core_sleeping,
  input wire core_return,
  input wire [63:0] ctx_live,
  output reg irq_take_q,
  output reg [14:0] vector_addr_q,
  output reg ctx_restore_q,
  output reg wake_q,
  output reg global_irq_enable_q,
  output wire [63:0] ctx_shadow
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam ST_RUN = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_WAKE = 2'd2;

  reg [7:0] irq_ctrl_q;
  reg [1:0] arm_q;
  reg edge_sel_q;
  reg [CHG_N-1:0] chg_flag_q;
  reg [CHG_N-1:0] chg_prev_q;
  reg ext_prev_q;
  reg [7:0] shd_q [0:7];
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] phase_q;
  reg [7:0] div_q;
  reg wake_cnt_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire [CHG_N:0] pins_sync;
  wire ext_s;
  wire [CHG_N-1:0] chg_s;
  wire q_en;
  wire q1;
  wire armed;
  wire ext_edge;
  wire [CHG_N-1:0] chg_edge;
  wire wr_acc;
  wire rd_setup;
  wire en_t0;
  wire en_ext;
  wire en_chg;
  wire en_per;
  wire any_en;
  wire take;
  integer i;

  // Decode a bus address against one word offset
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr[11:2] == ofs[11:2]);
    end
  endfunction

  // Shadow window: eight words from the shadow offset
  function shd_hit;
    input [11:0] addr;
    begin
      shd_hit = (addr[11:5] == `CIC_SHADOW_BASE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  cic_sync #(
    .WIDTH(CHG_N + 1)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({change_pins, ext_pin}),
    .sync_q(pins_sync)
  );

  assign ext_s = pins_sync[0];
  assign chg_s = pins_sync[CHG_N:1];

  // Edges are held off until the synchroniser and the previous-level flops carry real pin levels,
  // so a pin that idles high does not raise a false edge just after reset
  assign armed = (arm_q == 2'd3);

  // Rising edge when selected, falling otherwise
  assign ext_edge = armed & (edge_sel_q ? (ext_s & ~ext_prev_q) : (~ext_s & ext_prev_q));
  // Any toggle of a change pin counts, in either direction
  assign chg_edge = {CHG_N{armed}} & (chg_s ^ chg_prev_q);

  // Previous pin levels and the arming count, which stops once armed
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_prev_q <= 1'b0;
      chg_prev_q <= {CHG_N{1'b0}};
      arm_q <= 2'd0;
    end else begin
      ext_prev_q <= ext_s;
      chg_prev_q <= chg_s;
      if (!armed) begin
        arm_q <= arm_q + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle phases: one enable per Q phase, Q1 is decoded in phase 3

  // Last divider count; a divide of one gives an enable on every clock
  localparam [31:0] Q_LAST = Q_DIV - 1;

  assign q_en = ({24'h000000, div_q} == Q_LAST);
  assign q1 = q_en & (phase_q == 2'd3);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
      phase_q <= 2'd0;
    end else begin
      div_q <= q_en ? 8'h00 : div_q + 8'h01;
      if (q_en) begin
        phase_q <= phase_q + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable gating

  assign en_t0 = irq_ctrl_q[`CIC_B_TIMER0_EN] & irq_ctrl_q[`CIC_B_TIMER0_FLAG];
  assign en_ext = irq_ctrl_q[`CIC_B_PIN_EN] & irq_ctrl_q[`CIC_B_PIN_FLAG];
  assign en_chg = irq_ctrl_q[`CIC_B_CHANGE_EN] & irq_ctrl_q[`CIC_B_CHANGE_FLAG];
  // Peripheral requests also need the peripheral enable on top of their own enables
  assign en_per = irq_ctrl_q[`CIC_B_PERIPH_EN] & periph_irq_pending;
  assign any_en = en_t0 | en_ext | en_chg | en_per;

  // Pending enabled events are looked at once per cycle at Q1, independent of instruction length
  // Only raised in run state, so a sleeping core never sees an entry strobe
  assign take = q1 & irq_ctrl_q[`CIC_B_GLOBAL_EN] & any_en & (state_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes: no wait state, ready and read data come from flops loaded in the setup cycle

  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  ////////////////////////////////////////////////////////////////////////////
  // Control register: enables, flags and global enable

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_ctrl_q <= `CIC_CTRL_RST;
      edge_sel_q <= `CIC_OPTION_RST;
    end else begin
      if (wr_acc && hit(paddr, `CIC_OFS_CTRL)) begin
        irq_ctrl_q[7:1] <= pwdata[7:1];
      end
      if (wr_acc && hit(paddr, `CIC_OFS_OPTION)) begin
        edge_sel_q <= pwdata[`CIC_B_EDGE];
      end
      // Hardware sets win over a clearing write in the same cycle
      if (timer0_overflow) begin
        irq_ctrl_q[`CIC_B_TIMER0_FLAG] <= 1'b1;
      end
      if (ext_edge) begin
        irq_ctrl_q[`CIC_B_PIN_FLAG] <= 1'b1;
      end
      // Aggregate change bit is never written by software, it only mirrors the per-pin flags
      irq_ctrl_q[`CIC_B_CHANGE_FLAG] <= |chg_flag_q;
      // Entry clears global enable, return sets it; entry wins
      if (take) begin
        irq_ctrl_q[`CIC_B_GLOBAL_EN] <= 1'b0;
      end else if (core_return) begin
        irq_ctrl_q[`CIC_B_GLOBAL_EN] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin change flags: software writes zero to clear, new changes win

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chg_flag_q <= {CHG_N{1'b0}};
    end else if (wr_acc && hit(paddr, `CIC_OFS_CHGFLG)) begin
      chg_flag_q <= (chg_flag_q & pwdata[CHG_N-1:0]) | chg_edge;
    end else begin
      chg_flag_q <= chg_flag_q | chg_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow registers: captured on entry, software may rewrite them

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        shd_q[i] <= 8'h00;
      end
    end else if (take) begin
      for (i = 0; i < 8; i = i + 1) begin
        shd_q[i] <= ctx_live[8*i +: 8];
      end
      // Timeout and power-down bits are left to the core
      shd_q[`CIC_SHD_STATUS] <= ctx_live[15:8] & `CIC_STATUS_KEEP;
    end else if (wr_acc && shd_hit(paddr)) begin
      shd_q[paddr[4:2]] <= pwdata[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_shd
      assign ctx_shadow[8*g +: 8] = shd_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sleep and wake sequencing

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (core_sleeping) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Any enabled source wakes the core, global enable or not
        if (any_en) begin
          state_d = ST_WAKE;
        end else if (!core_sleeping) begin
          state_d = ST_RUN;
        end
      end
      ST_WAKE: begin
        // Hold vectoring off until the next instruction has had a whole cycle
        if (q1 && wake_cnt_q) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      wake_cnt_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_q <= (state_q == ST_SLEEP) && (state_d == ST_WAKE);
      if (state_q != ST_WAKE) begin
        wake_cnt_q <= 1'b0;
      end else if (q1) begin
        wake_cnt_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core strobes: entry, vector, restore

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_take_q <= 1'b0;
      vector_addr_q <= `CIC_VECTOR;
      ctx_restore_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      // Core flushes prefetch, pushes PC and jumps to the vector on this strobe
      irq_take_q <= take;
      vector_addr_q <= `CIC_VECTOR;
      // Core pops its stack and loads the shadow bytes on this strobe
      ctx_restore_q <= core_return & ~take;
      global_irq_enable_q <= irq_ctrl_q[`CIC_B_GLOBAL_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, registered in the setup cycle

  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (hit(paddr, `CIC_OFS_CTRL)) begin
      rdata_d[7:0] = irq_ctrl_q;
    end else if (hit(paddr, `CIC_OFS_OPTION)) begin
      rdata_d[`CIC_B_EDGE] = edge_sel_q;
    end else if (hit(paddr, `CIC_OFS_CHGFLG)) begin
      rdata_d[CHG_N-1:0] = chg_flag_q;
    end else if (hit(paddr, `CIC_OFS_STATE)) begin
      rdata_d[1:0] = state_q;
      rdata_d[5:4] = phase_q;
    end else if (shd_hit(paddr)) begin
      rdata_d[7:0] = shd_q[paddr[4:2]];
    end else begin
      err_d = 1'b1;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & err_d;
      if (rd_setup) begin
        prdata <= rdata_d;
      end
    end
  end

endmodule

// ==== verification/cic_monitor.sv ====
// Port checker of the interrupt controller
`timescale 1ns/1ns
module cic_monitor (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire core_return,
  input wire [63:0] ctx_live,
  input wire irq_take_q,
  input wire [14:0] vector_addr_q,
  input wire ctx_restore_q,
  input wire global_irq_enable_q,
  input wire [63:0] ctx_shadow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////
  // Bus answers
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Entry
  vector_fixed_a: assert property (irq_take_q |-> vector_addr_q == 15'h0004)
    else $error("bad vector");
  take_single_a: assert property (irq_take_q |=> !irq_take_q)
    else $error("entry repeated");
  take_clears_gie_a: assert property (irq_take_q |-> ##2 !global_irq_enable_q)
    else $error("global enable kept");
  shadow_save_a: assert property (irq_take_q |-> ctx_shadow == ($past(ctx_live) & 64'hffffffffffffe7ff))
    else $error("context not saved");
  // Return
  ret_restore_a: assert property (core_return |=> ctx_restore_q || irq_take_q)
    else $error("no restore");
  restore_cause_a: assert property (ctx_restore_q |-> $past(core_return))
    else $error("restore without return");
  ret_gie_a: assert property (core_return |-> ##2 (global_irq_enable_q || $past(irq_take_q)))
    else $error("return left global clear");
endmodule

bind cic_top cic_monitor mon (.sys_clk, .rst, .psel, .penable, .pready, .pslverr, .core_return, .ctx_live,
  .irq_take_q, .vector_addr_q, .ctx_restore_q, .global_irq_enable_q, .ctx_shadow);

// ==== verification/cic_core_model.sv ====
// Core model: answers each vector entry with a return after the routine length
`timescale 1ns/1ns
module cic_core_model (
  input wire sys_clk,
  input wire rst,
  input wire irq_take_q,
  input wire [7:0] routine_len,
  output logic core_return,
  output logic [63:0] ctx_live
);
  logic [7:0] cnt_q;
  ////////////////////
  // Load the routine length on entry, then return after the routine
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      core_return <= 1'b0;
    end else begin
      cnt_q <= irq_take_q ? routine_len : cnt_q - {7'h00, cnt_q != 8'h00};
      core_return <= cnt_q == 8'h01;
    end
  end
  // Live context changes every cycle so a stale capture shows
  always @(posedge sys_clk) ctx_live <= {$urandom, $urandom};
endmodule

// ==== verification/tb.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
module tb;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, ext_pin = 0, timer0_overflow = 0, periph_irq_pending = 0, core_sleeping = 0;
  logic core_return, irq_take_q, ctx_restore_q, wake_q, global_irq_enable_q;
  logic [5:0] change_pins = 0;
  logic [63:0] ctx_live, ctx_shadow;
  logic [14:0] vector_addr_q;
  logic [7:0] v, routine_len = 8'd30;
  logic [7:0] en[3] = '{8'h20, 8'h10, 8'h40};
  logic [7:0] fl[3] = '{8'h04, 8'h02, 8'h00};
  int fails = 0, cmp_count = 0, takes = 0, wakes = 0, n0, k, s, i;
  ////////////////////
  always #4 sys_clk = ~sys_clk;
  // Count entries and wake pulses
  always @(posedge sys_clk) begin
    takes <= takes + irq_take_q;
    wakes <= wakes + wake_q;
  end
  cic_top #(.CHG_N(6), .Q_DIV(1)) DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_pin, .change_pins, .timer0_overflow, .periph_irq_pending, .core_sleeping,
    .core_return, .ctx_live, .irq_take_q, .vector_addr_q, .ctx_restore_q, .wake_q, .global_irq_enable_q,
    .ctx_shadow);
  cic_core_model core (.sys_clk, .rst, .irq_take_q, .routine_len, .core_return, .ctx_live);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] x);
    cmp_count++;
    if (x !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One bus transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1;
    do begin
      tick(1);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // One idle cycle keeps the next setup out of this time step
    tick(1);
  endtask
  initial begin
    i = $urandom(81);
    tick(2);
    rst <= 0;
    tick(1);
    apb(0, 0, 0);
    chk("control after reset", 0, rd);
    apb(0, 12'h004, 0);
    chk("edge select after reset", 1, rd);
    apb(0, 12'h100, 0);
    chk("unmapped error", 1, err);
    $display("reset test done");
    for (s = 0; s < 3; s++) begin
      n0 = takes;
      routine_len <= 8'd20 + 8'($urandom % 20);
      apb(1, 0, 0);
      if (s == 0) timer0_overflow <= 1;
      if (s == 1) ext_pin <= 1;
      if (s == 2) periph_irq_pending <= 1;
      tick(1);
      timer0_overflow <= 0;
      tick(8);
      chk("entry with global clear", n0, takes);
      apb(0, 0, 0);
      chk("source flag", fl[s], rd & 8'h06);
      apb(1, 0, 8'h80 | en[s] | fl[s]);
      k = 0;
      while (takes == n0 && k < 12) begin
        tick(1);
        k++;
      end
      chk("pending entry", n0 + 1, takes);
      ext_pin <= 0;
      periph_irq_pending <= 0;
      apb(1, 0, en[s]);
      tick(60);
      chk("no repeat entry", n0 + 1, takes);
      apb(0, 0, 0);
      chk("global after return", 8'h80 | en[s], rd);
      $display("source test %0d done", s);
    end
    for (s = 0; s < 2; s++) begin
      apb(1, 12'h004, s);
      ext_pin <= ~s[0];
      tick(6);
      apb(1, 0, 0);
      ext_pin <= s[0];
      tick(6);
      apb(0, 0, 0);
      chk("pin flag selected edge", 2, rd & 2);
      apb(1, 0, 0);
      ext_pin <= ~s[0];
      tick(6);
      apb(0, 0, 0);
      chk("pin flag other edge", 0, rd & 2);
    end
    $display("edge test done");
    i = $urandom % 6;
    change_pins <= change_pins ^ (6'h01 << i);
    tick(6);
    apb(0, 12'h008, 0);
    chk("change flags", 1 << i, rd);
    apb(1, 0, 0);
    apb(0, 0, 0);
    chk("aggregate kept", 1, rd);
    apb(1, 12'h008, 0);
    tick(2);
    apb(0, 0, 0);
    chk("aggregate cleared", 0, rd);
    v = $urandom;
    apb(1, 12'h020, v);
    apb(0, 12'h020, 0);
    chk("shadow read", v, rd);
    chk("shadow out", v, ctx_shadow[7:0]);
    $display("change and shadow test done");
    n0 = takes;
    k = wakes;
    core_sleeping <= 1;
    apb(1, 0, 8'h20);
    timer0_overflow <= 1;
    tick(1);
    timer0_overflow <= 0;
    // The core is awake once the wake pulse has gone out
    i = 0;
    while (wakes == k && i < 20) begin
      tick(1);
      i++;
    end
    core_sleeping <= 0;
    apb(0, 12'h00c, 0);
    chk("wake hold state", 2, rd & 3);
    tick(10);
    chk("wake pulse", k + 1, wakes);
    chk("no entry on wake", n0, takes);
    apb(1, 0, 8'h80);
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(1);
    apb(0, 0, 0);
    chk("control after second reset", 0, rd);
    $display("sleep and reset test done");
    tally_and_finish();
  end
endmodule
